// ==== sum_pkg.sv ====
// constants and types for the supply undervoltage monitor
//
// Contract
// - A three-bit trip level select picks one of eight ascending levels, 000 is 2.0V and 111 is 4.4V.
// - Status bit 5 reads high while the comparator reports supply below the selected level.
// - Enable bit 4 switches the detector on when one, off when zero, and resets to zero.
// - Bits 7, 6 and 3 of the control register ignore writes and read as zero.
// - The detector keeps running in power-down while enabled.
// - The request flag sets only after a fixed delay following the status bit rising; the code also sets it at once on a write of one to the flag register.
// - The monitor request is one source of a shared multifunction interrupt.
// - A request flag set in sleep or idle with the detector enabled wakes the device.
// - The status bit follows every comparator transition and never latches the first; the code follows them only while enabled and holds zero while disabled.
// - Once set, the request flag stays set until serviced or cleared by software.
package sum_pkg;

  // ********************************
  // register map
  // ********************************
  localparam logic [3:0] SUM_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] SUM_ADDR_IRQFLAG = 4'h4;
  localparam logic [3:0] SUM_ADDR_STATUS  = 4'h8;
  localparam logic [3:0] SUM_ADDR_MASK    = 4'hC;

  localparam int SUM_POS_LEVEL  = 0;
  localparam int SUM_POS_ENABLE = 4;
  localparam int SUM_POS_UNDER  = 5;
  localparam logic [7:0] SUM_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SUM_CONTROL_WMASK = 8'h17;
  localparam logic [1:0] SUM_STATUS_RESET  = 2'h0;
  localparam logic [1:0] SUM_MASK_RESET    = 2'h0;
  localparam logic [1:0] SUM_RESP_OKAY     = 2'h0;
  localparam logic [1:0] SUM_RESP_SLVERR   = 2'h2;

  // ********************************
  // timing
  // ********************************
  localparam int SUM_CLK_MHZ         = 25;
  localparam int SUM_IRQ_DELAY_US    = 100;
  localparam int SUM_IRQ_DELAY_CYC   = SUM_IRQ_DELAY_US * SUM_CLK_MHZ;
  localparam int SUM_SETTLE_DELAY_US = 150;
  localparam int SUM_SETTLE_CYC      = SUM_SETTLE_DELAY_US * SUM_CLK_MHZ;

  typedef enum logic [2:0] {
    SUM_LEVEL_2V0 = 3'b000,
    SUM_LEVEL_2V2 = 3'b001,
    SUM_LEVEL_2V4 = 3'b010,
    SUM_LEVEL_2V7 = 3'b011,
    SUM_LEVEL_3V0 = 3'b100,
    SUM_LEVEL_3V3 = 3'b101,
    SUM_LEVEL_3V6 = 3'b110,
    SUM_LEVEL_4V4 = 3'b111
  } sum_level_type;

  typedef struct packed {
    logic          monitorEnable;
    sum_level_type tripLevelSelect;
  } sum_ctrl_type;

endpackage

// ==== sum_delay_timer.sv ====
// qualifying timer: pulses once a level has held high for a set count
`timescale 1ns/1ps
module sum_delay_timer #(
  parameter int COUNT = 2500
) (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic level,
  output logic      done
);
  import sum_pkg::*;

  logic [23:0] count;
  logic [23:0] next_count;
  logic        fired;
  logic        next_fired;
  logic        next_done;

  always_comb begin
    next_count = count;
    next_fired = fired;
    next_done  = 1'b0;
    if (!level) begin
      next_count = 24'h000000;
      next_fired = 1'b0;
    end else if (!fired) begin
      if (count == 24'(COUNT - 1)) begin
        next_done  = 1'b1;
        next_fired = 1'b1;
      end else begin
        next_count = count + 24'h000001;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 24'h000000;
      fired <= 1'b0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      fired <= next_fired;
      done  <= next_done;
    end
  end
endmodule // sum_delay_timer

// ==== sum_supply_monitor.sv ====
// supply undervoltage monitor: control register, status, delayed request, wake
`timescale 1ns/1ps
module sum_supply_monitor #(
  parameter int IRQ_DELAY = sum_pkg::SUM_IRQ_DELAY_CYC
) (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire logic [3:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [3:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               compBelow,
  input  wire logic               lowPower,
  output sum_pkg::sum_ctrl_type   analogControl,
  output logic                    monitorIrqFlag,
  output logic                    wakeRequest,
  output logic                    irq
);
  import sum_pkg::*;

  // register reset value placed in struct order, where enable sits just above the level
  localparam sum_ctrl_type CTRL_RESET = '{
    monitorEnable:   SUM_CONTROL_RESET[SUM_POS_ENABLE],
    tripLevelSelect: sum_level_type'(SUM_CONTROL_RESET[SUM_POS_LEVEL +: 3])
  };

  // ********************************
  // comparator synchroniser
  // ********************************
  logic syncMeta;
  logic syncOut;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      syncMeta <= 1'b0;
      syncOut  <= 1'b0;
    end else begin
      syncMeta <= compBelow;
      syncOut  <= syncMeta;
    end
  end

  // ********************************
  // state
  // ********************************
  sum_ctrl_type ctrl;
  sum_ctrl_type next_ctrl;
  logic         underStatus;
  logic         next_underStatus;
  logic         next_irqFlag;
  logic [1:0]   status;
  logic [1:0]   next_status;
  logic [1:0]   mask;
  logic [1:0]   next_mask;
  logic         next_wake;
  logic         next_irq;
  logic         delayDone;
  logic         underPrev;
  logic         next_underPrev;

  logic         awHeld;
  logic         next_awHeld;
  logic [3:0]   awAddr;
  logic [3:0]   next_awAddr;
  logic         wHeld;
  logic         next_wHeld;
  logic [31:0]  wData;
  logic [31:0]  next_wData;
  logic         wStrb0;
  logic         next_wStrb0;
  logic         next_awready;
  logic         next_wready;
  logic         next_bvalid;
  logic [1:0]   next_bresp;
  logic         next_arready;
  logic         next_rvalid;
  logic [31:0]  next_rdata;
  logic [1:0]   next_rresp;

  function automatic logic mapped(input logic [3:0] addr);
    mapped = (addr == SUM_ADDR_CONTROL) || (addr == SUM_ADDR_IRQFLAG) ||
             (addr == SUM_ADDR_STATUS) || (addr == SUM_ADDR_MASK);
  endfunction

  // comparator only trusted while enabled; analog holds state in power-down
  sum_delay_timer #(
    .COUNT (IRQ_DELAY)
  ) u_delay (
    .mclk    (mclk),
    .reset_n (reset_n),
    .level   (underStatus),
    .done    (delayDone)
  );

  // ********************************
  // next-state logic
  // ********************************
  logic doWrite;
  logic doRead;
  logic rdClearStatus;
  logic wrFlagClear;
  logic wrFlagSet;
  logic riseEvent;
  logic [7:0] ctrlRead;

  always_comb begin
    next_awHeld  = awHeld;
    next_awAddr  = awAddr;
    next_wHeld   = wHeld;
    next_wData   = wData;
    next_wStrb0  = wStrb0;
    next_awready = 1'b0;
    next_wready  = 1'b0;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_arready = 1'b0;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    next_ctrl    = ctrl;
    next_mask    = mask;
    doWrite      = 1'b0;
    doRead       = 1'b0;
    rdClearStatus = 1'b0;
    wrFlagClear  = 1'b0;
    wrFlagSet    = 1'b0;
    ctrlRead     = 8'h00;

    ctrlRead[SUM_POS_LEVEL +: 3] = ctrl.tripLevelSelect;
    ctrlRead[SUM_POS_ENABLE]     = ctrl.monitorEnable;
    ctrlRead[SUM_POS_UNDER]      = underStatus;

    // write path: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld  = 1'b1;
      next_wData  = s_axi_wdata;
      next_wStrb0 = s_axi_wstrb[0];
    end
    if (!awHeld && !s_axi_awready && !s_axi_bvalid) begin
      next_awready = s_axi_awvalid;
    end
    if (!wHeld && !s_axi_wready && !s_axi_bvalid) begin
      next_wready = s_axi_wvalid;
    end
    if (awHeld && wHeld && !s_axi_bvalid) begin
      doWrite     = 1'b1;
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = mapped(awAddr) ? SUM_RESP_OKAY : SUM_RESP_SLVERR;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (doWrite && wStrb0) begin
      case (awAddr)
        SUM_ADDR_CONTROL: begin
          // only level and enable are writable, bits 7,6,5,3 drop
          next_ctrl.tripLevelSelect = sum_level_type'(wData[SUM_POS_LEVEL +: 3]);
          next_ctrl.monitorEnable   = wData[SUM_POS_ENABLE];
        end
        SUM_ADDR_IRQFLAG: begin
          wrFlagSet   = wData[0];
          wrFlagClear = !wData[0];
        end
        SUM_ADDR_MASK: begin
          next_mask = wData[1:0];
        end
        default: begin
        end
      endcase
    end

    // read path
    if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid) begin
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      doRead      = 1'b1;
      next_rvalid = 1'b1;
      next_rresp  = mapped(s_axi_araddr) ? SUM_RESP_OKAY : SUM_RESP_SLVERR;
      next_rdata  = 32'h00000000;
      case (s_axi_araddr)
        SUM_ADDR_CONTROL: next_rdata = {24'h000000, ctrlRead & ~SUM_CONTROL_WMASK |
                                        ctrlRead & SUM_CONTROL_WMASK};
        SUM_ADDR_IRQFLAG: next_rdata = {31'h00000000, monitorIrqFlag};
        SUM_ADDR_STATUS: begin
          next_rdata    = {30'h00000000, status};
          rdClearStatus = 1'b1;
        end
        SUM_ADDR_MASK:    next_rdata = {30'h00000000, mask};
        default:          next_rdata = 32'h00000000;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // ********************************
  // monitor behaviour
  // ********************************
  always_comb begin
    // follows every comparator edge while enabled, held at zero while disabled, no latching
    next_underStatus = ctrl.monitorEnable && syncOut;
    next_underPrev   = underStatus;
    riseEvent        = underStatus && !underPrev;

    // set wins over software clear
    next_irqFlag = monitorIrqFlag;
    if (wrFlagClear) begin
      next_irqFlag = 1'b0;
    end
    if (wrFlagSet) begin
      next_irqFlag = 1'b1;
    end
    if (delayDone && ctrl.monitorEnable) begin
      next_irqFlag = 1'b1;
    end

    // status bit0: request flag set, bit1: undervoltage rising edge
    next_status = status;
    if (rdClearStatus) begin
      next_status = 2'h0;
    end
    if (delayDone && ctrl.monitorEnable) begin
      next_status[0] = 1'b1;
    end
    if (riseEvent) begin
      next_status[1] = 1'b1;
    end

    // wake only on a fresh assertion, so a preset flag gives no wake
    // a disable landing in the same cycle suppresses the wake
    next_wake = lowPower && ctrl.monitorEnable && next_ctrl.monitorEnable &&
                next_irqFlag && !monitorIrqFlag;
    next_irq  = |(next_status & next_mask);
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl           <= CTRL_RESET;
      underStatus    <= 1'b0;
      underPrev      <= 1'b0;
      monitorIrqFlag <= 1'b0;
      status         <= SUM_STATUS_RESET;
      mask           <= SUM_MASK_RESET;
      wakeRequest    <= 1'b0;
      irq            <= 1'b0;
      analogControl  <= CTRL_RESET;
      awHeld         <= 1'b0;
      awAddr         <= 4'h0;
      wHeld          <= 1'b0;
      wData          <= 32'h00000000;
      wStrb0         <= 1'b0;
      s_axi_awready  <= 1'b0;
      s_axi_wready   <= 1'b0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= SUM_RESP_OKAY;
      s_axi_arready  <= 1'b0;
      s_axi_rvalid   <= 1'b0;
      s_axi_rdata    <= 32'h00000000;
      s_axi_rresp    <= SUM_RESP_OKAY;
    end else begin
      ctrl           <= next_ctrl;
      underStatus    <= next_underStatus;
      underPrev      <= next_underPrev;
      monitorIrqFlag <= next_irqFlag;
      status         <= next_status;
      mask           <= next_mask;
      wakeRequest    <= next_wake;
      irq            <= next_irq;
      analogControl  <= next_ctrl;
      awHeld         <= next_awHeld;
      awAddr         <= next_awAddr;
      wHeld          <= next_wHeld;
      wData          <= next_wData;
      wStrb0         <= next_wStrb0;
      s_axi_awready  <= next_awready;
      s_axi_wready   <= next_wready;
      s_axi_bvalid   <= next_bvalid;
      s_axi_bresp    <= next_bresp;
      s_axi_arready  <= next_arready;
      s_axi_rvalid   <= next_rvalid;
      s_axi_rdata    <= next_rdata;
      s_axi_rresp    <= next_rresp;
    end
  end
endmodule // sum_supply_monitor

// ==== sum_supply_monitor_properties.sv ====
// concurrent checks on the ports of the supply undervoltage monitor
`timescale 1ns/1ps
module sum_supply_monitor_properties #(
  parameter int IRQ_DELAY = 8
) (
  input logic                  mclk,
  input logic                  reset_n,
  input logic                  s_axi_awvalid,
  input logic                  compBelow,
  input logic                  lowPower,
  input sum_pkg::sum_ctrl_type analogControl,
  input logic                  monitorIrqFlag,
  input logic                  wakeRequest
);
  import sum_pkg::*;
  // ****************
  // helper logic
  // ****************
  logic [3:0]  awSeen;
  logic [15:0] lowRun;
  logic        busWrite;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // window after a write address is offered, when software may move state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      awSeen <= 4'h0;
      lowRun <= 16'h0000;
    end else begin
      awSeen <= {awSeen[2:0], s_axi_awvalid};
      // wide enough for the full-length delay, saturates so it never wraps back
      if (!(compBelow && analogControl.monitorEnable)) begin
        lowRun <= 16'h0000;
      end else if (lowRun != 16'hFFFF) begin
        lowRun <= lowRun + 16'h0001;
      end
    end
  end
  assign busWrite = |awSeen;
  property p_ctrl_reset;
    $rose(reset_n) |-> analogControl == 4'h0;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not clear");
  property p_ctrl_write;
    !$stable(analogControl) |-> busWrite;
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control moved alone");
  property p_flag_sticky;
    $fell(monitorIrqFlag) |-> busWrite;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
  // margin of two is spare; the enable copy loads in the same cycle as the internal enable
  property p_flag_delay;
    $rose(monitorIrqFlag) && !busWrite |-> lowRun >= 16'(IRQ_DELAY - 2);
  endproperty
  a_flag_delay: assert property (p_flag_delay) else $error("flag early");
  property p_flag_due;
    lowRun == 16'(IRQ_DELAY + 8) |-> monitorIrqFlag;
  endproperty
  a_flag_due: assert property (p_flag_due) else $error("flag late");
  property p_wake_due;
    $rose(monitorIrqFlag) && lowPower && analogControl.monitorEnable && !busWrite
      |-> ##[0:1] wakeRequest;
  endproperty
  a_wake_due: assert property (p_wake_due) else $error("no wake");
  property p_wake_pulse;
    wakeRequest |=> !wakeRequest;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
  property p_wake_cause;
    wakeRequest |-> monitorIrqFlag && !$past(monitorIrqFlag);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake on old flag");
  property p_wake_off;
    !analogControl.monitorEnable |-> !wakeRequest;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake while off");
endmodule // sum_supply_monitor_properties

bind sum_supply_monitor sum_supply_monitor_properties #(.IRQ_DELAY(IRQ_DELAY)) u_props (
  .mclk, .reset_n, .s_axi_awvalid, .compBelow, .lowPower, .analogControl,
  .monitorIrqFlag, .wakeRequest);

// ==== tb.sv ====
// self-checking bench for the supply undervoltage monitor
`timescale 1ns/1ps
module tb;
  import sum_pkg::*;
  localparam int DLY = 8;
  logic         mclk, reset_n, compBelow, lowPower, irq, monitorIrqFlag, wakeRequest;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready;
  logic [3:0]   s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  sum_ctrl_type analogControl;
  int           miscompares, checks_done, wakes;

  sum_supply_monitor #(.IRQ_DELAY(DLY)) u_dut (
    .mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .compBelow, .lowPower,
    .analogControl, .monitorIrqFlag, .wakeRequest, .irq);

  always #20 mclk = ~mclk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // a bus wait that runs out ends the run at once
  task automatic hang(input bit ok);
    if (!ok) begin
      miscompares++;
      $display("unexpected at %0t: no bus answer", $time);
      test_done();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // only the four mapped words answer okay
  function automatic logic [1:0] resp_for(input logic [3:0] a);
    if (a == SUM_ADDR_CONTROL || a == SUM_ADDR_IRQFLAG ||
        a == SUM_ADDR_STATUS || a == SUM_ADDR_MASK) begin
      return SUM_RESP_OKAY;
    end
    return SUM_RESP_SLVERR;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    bit ok;
    ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        ok = 1'b1;
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(resp_for(a)));
      end
    end
    hang(ok);
    @(posedge mclk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bit ok;
    ok = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        ok = 1'b1;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(resp_for(a)));
      end
    end
    hang(ok);
    @(posedge mclk);
  endtask

  // supply dips back above the level briefly, then counts wake pulses
  task automatic dip;
    compBelow <= 1'b0;
    cyc(5);
    compBelow <= 1'b1;
    wakes = 0;
    repeat (DLY + 20) begin
      @(posedge mclk);
      if (wakeRequest === 1'b1) wakes++;
    end
  endtask

  initial begin
    {mclk, reset_n, compBelow, lowPower, s_axi_awvalid, s_axi_wvalid} = 6'h00;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
    miscompares = 0;
    checks_done = 0;
    cyc(10);
    reset_n <= 1'b1;
    @(posedge mclk);
    chk(32'(analogControl), 32'h0);
    rd(SUM_ADDR_CONTROL, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(SUM_ADDR_CONTROL, 32'hFFFFFFF8 | i, 4'hF);
      rd(SUM_ADDR_CONTROL, 32'h10 | i);
      chk(32'(analogControl), 32'h8 | i);
    end
    wr(SUM_ADDR_CONTROL, 32'h0, 4'h0);
    rd(SUM_ADDR_CONTROL, 32'h17);
    wr(4'h6, 32'h0, 4'hF);
    rd(SUM_ADDR_CONTROL, 32'h17);
    rd(4'h6, 32'h0);
    wr(SUM_ADDR_CONTROL, 32'h3, 4'hF);
    compBelow <= 1'b1;
    cyc(DLY + 20);
    rd(SUM_ADDR_CONTROL, 32'h3);
    chk(32'(monitorIrqFlag), 32'h0);
    wr(SUM_ADDR_CONTROL, 32'h13, 4'hF);
    cyc(SUM_SETTLE_CYC);
    rd(SUM_ADDR_CONTROL, 32'h33);
    cyc(DLY + 8);
    chk(32'(monitorIrqFlag), 32'h1);
    chk(32'(irq), 32'h0);
    wr(SUM_ADDR_MASK, 32'h3, 4'hF);
    cyc(2);
    chk(32'(irq), 32'h1);
    rd(SUM_ADDR_STATUS, 32'h3);
    cyc(2);
    chk(32'(irq), 32'h0);
    rd(SUM_ADDR_STATUS, 32'h0);
    compBelow <= 1'b0;
    cyc(5);
    rd(SUM_ADDR_CONTROL, 32'h13);
    compBelow <= 1'b1;
    cyc(5);
    rd(SUM_ADDR_CONTROL, 32'h33);
    cyc(DLY + 8);
    chk(32'(monitorIrqFlag), 32'h1);
    wr(SUM_ADDR_IRQFLAG, 32'h0, 4'hF);
    chk(32'(monitorIrqFlag), 32'h0);
    lowPower <= 1'b1;
    dip();
    chk(wakes, 32'h1);
    chk(32'(monitorIrqFlag), 32'h1);
    lowPower <= 1'b0;
    wr(SUM_ADDR_IRQFLAG, 32'h0, 4'hF);
    chk(32'(monitorIrqFlag), 32'h0);
    wr(SUM_ADDR_IRQFLAG, 32'h1, 4'hF);
    chk(32'(monitorIrqFlag), 32'h1);
    lowPower <= 1'b1;
    dip();
    chk(wakes, 32'h0);
    chk(32'(monitorIrqFlag), 32'h1);
    test_done();
  end
endmodule // tb
